// [clock_select_pkg.sv]
/*
  constants for the system clock select and failover block: register map,
  control field layout, reset values, source codes, unlock patterns, states.
  assumes a 32-bit avalon-mm slave with byte addresses.
*/
package clock_select_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  // clock_control_reg fields
  localparam int PREC_EN_BIT = 7;
  localparam int WDOG_EN_BIT = 5;
  localparam int PRIM_FD_BIT = 4;
  localparam int WDOG_FD_BIT = 3;
  localparam int SEL_MSB = 2;
  localparam logic [7:0] CTRL_RESET = 8'ha0;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hbf;
  // status register fields
  localparam int ST_PRIM_FAIL_BIT = 0;
  localparam int ST_WDOG_FAIL_BIT = 1;
  localparam int ST_HALTED_BIT = 2;
  localparam int ST_WDOG_DEAD_BIT = 3;
  localparam int ST_LOCK_LSB = 4;
  // unlock patterns
  localparam logic [7:0] UNLOCK_FIRST = 8'he7;
  localparam logic [7:0] UNLOCK_SECOND = 8'h18;
  // sys_clock_source_field codes
  localparam logic [2:0] SRC_PREC_FAST = 3'h0;
  localparam logic [2:0] SRC_PREC_SLOW = 3'h1;
  localparam logic [2:0] SRC_EXT = 3'h2;
  localparam logic [2:0] SRC_WDOG = 3'h3;
  // system clocks without a watchdog oscillator edge before failure
  localparam int WDOG_FAIL_COUNT = 8004;
  typedef enum logic [2:0] {
    LOCK_IDLE = 3'b001,
    LOCK_HALF = 3'b010,
    LOCK_OPEN = 3'b100
  } unlock_type;
endpackage

// [system_clock_select_failover.sv]
/*
  system clock source select with write-lock, primary failover to the
  watchdog oscillator and a watchdog oscillator loss detector.
  assumes: i_clock is the selected system clock; oscillator pins are
  asynchronous; the analog slow-clock comparator sits outside.
*/
`timescale 1ns/10ps
`default_nettype none
module system_clock_select_failover #(
  parameter int WDOG_FAIL_COUNT = clock_select_pkg::WDOG_FAIL_COUNT
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // avalon-mm slave
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // oscillator monitors, asynchronous
  input wire logic i_wdog_osc_clock,
  input wire logic i_primary_osc_slow,
  // clock tree control
  output logic [2:0] o_sys_clock_source_field,
  output logic o_precision_osc_en,
  output logic o_wdog_osc_en,
  output logic o_halted,
  // non-maskable events, one cycle
  output logic o_primary_fail_nmi,
  output logic o_wdog_fail_nmi
);
  localparam int CNT_W = $clog2(WDOG_FAIL_COUNT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WDOG_FAIL_COUNT - 1);

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    clock_select_pkg::unlock_type lock;
    logic [7:0] ctrl;
    logic prim_flag;
    logic wdog_flag;
    logic wdog_dead;
    logic halted;
    logic prim_nmi;
    logic wdog_nmi;
    logic [CNT_W-1:0] wd_count;
    logic wd_s1;
    logic wd_s2;
    logic wd_s3;
    logic slow_s1;
    logic slow_s2;
    logic slow_s3;
  } state_type;

  state_type st_q;
  state_type st_d;

  // true when the selected source is one this block knows to be running
  function automatic logic source_alive(input logic [7:0] c);
    case (c[clock_select_pkg::SEL_MSB:0])
      clock_select_pkg::SRC_PREC_FAST,
      clock_select_pkg::SRC_PREC_SLOW: source_alive = c[clock_select_pkg::PREC_EN_BIT];
      clock_select_pkg::SRC_EXT: source_alive = 1'b1;
      clock_select_pkg::SRC_WDOG: source_alive = c[clock_select_pkg::WDOG_EN_BIT];
      default: source_alive = 1'b0;
    endcase
  endfunction

  logic bus_req;
  logic take;
  logic ctrl_wr;
  logic stat_wr;
  logic [7:0] wbyte;
  logic wd_edge;
  logic prim_event;
  logic [31:0] status_word;

  assign bus_req = i_read | i_write;
  assign take = bus_req & ~st_q.waitreq;
  assign wbyte = i_writedata[7:0];
  // device frozen once halted: no more writes land
  assign ctrl_wr = take & i_write & (i_address == clock_select_pkg::CTRL_OFFSET) & ~st_q.halted;
  assign stat_wr = take & i_write & (i_address == clock_select_pkg::STATUS_OFFSET) & ~st_q.halted;
  assign wd_edge = st_q.wd_s2 & ~st_q.wd_s3;
  // a dead watchdog oscillator blinds the primary detector
  assign prim_event = st_q.slow_s2 & ~st_q.slow_s3 & st_q.ctrl[clock_select_pkg::PRIM_FD_BIT]
                      & ~st_q.wdog_dead;
  always_comb
  begin
    status_word = 32'h0;
    status_word[clock_select_pkg::ST_PRIM_FAIL_BIT] = st_q.prim_flag;
    status_word[clock_select_pkg::ST_WDOG_FAIL_BIT] = st_q.wdog_flag;
    status_word[clock_select_pkg::ST_HALTED_BIT] = st_q.halted;
    status_word[clock_select_pkg::ST_WDOG_DEAD_BIT] = st_q.wdog_dead;
    status_word[clock_select_pkg::ST_LOCK_LSB +: 3] = st_q.lock;
  end

  always_comb
  begin
    st_d = st_q;
    st_d.prim_nmi = 1'b0;
    st_d.wdog_nmi = 1'b0;
    // synchronisers
    st_d.wd_s1 = i_wdog_osc_clock;
    st_d.wd_s2 = st_q.wd_s1;
    st_d.wd_s3 = st_q.wd_s2;
    st_d.slow_s1 = i_primary_osc_slow;
    st_d.slow_s2 = st_q.slow_s1;
    st_d.slow_s3 = st_q.slow_s2;
    // one wait cycle, then the request is taken
    st_d.waitreq = ~(bus_req & st_q.waitreq);
    if (bus_req & st_q.waitreq)
    begin
      case (i_address)
        clock_select_pkg::CTRL_OFFSET: st_d.rdata = {24'h0, st_q.ctrl};
        clock_select_pkg::STATUS_OFFSET: st_d.rdata = status_word;
        default: st_d.rdata = 32'h0;
      endcase
    end
    // unlock sequencer; only control writes move it
    if (ctrl_wr)
    begin
      case (st_q.lock)
        clock_select_pkg::LOCK_IDLE:
          if (wbyte == clock_select_pkg::UNLOCK_FIRST)
            st_d.lock = clock_select_pkg::LOCK_HALF;
        clock_select_pkg::LOCK_HALF:
          if (wbyte == clock_select_pkg::UNLOCK_SECOND)
            st_d.lock = clock_select_pkg::LOCK_OPEN;
          else if (wbyte != clock_select_pkg::UNLOCK_FIRST)
            st_d.lock = clock_select_pkg::LOCK_IDLE;
        clock_select_pkg::LOCK_OPEN:
        begin
          // select codes cover rc fast/slow, external and watchdog
          st_d.ctrl = wbyte & clock_select_pkg::CTRL_WRITE_MASK;
          st_d.lock = clock_select_pkg::LOCK_IDLE;
        end
        default: st_d.lock = clock_select_pkg::LOCK_IDLE;
      endcase
    end
    // write one to clear; a new event in the same cycle wins
    if (stat_wr)
    begin
      if (wbyte[clock_select_pkg::ST_PRIM_FAIL_BIT])
        st_d.prim_flag = 1'b0;
      if (wbyte[clock_select_pkg::ST_WDOG_FAIL_BIT])
        st_d.wdog_flag = 1'b0;
    end
    // primary failover
    if (prim_event)
    begin
      st_d.prim_nmi = 1'b1;
      st_d.prim_flag = 1'b1;
      if (st_q.ctrl[clock_select_pkg::WDOG_EN_BIT] &&
          st_q.ctrl[clock_select_pkg::SEL_MSB:0] != clock_select_pkg::SRC_WDOG)
        st_d.ctrl[clock_select_pkg::SEL_MSB:0] = clock_select_pkg::SRC_WDOG;
    end
    // watchdog oscillator loss detector
    if (!st_q.ctrl[clock_select_pkg::WDOG_FD_BIT] || st_q.wdog_dead || wd_edge)
      st_d.wd_count = '0;
    else if (st_q.wd_count == CNT_LAST)
    begin
      st_d.wd_count = '0;
      st_d.wdog_dead = 1'b1;
      st_d.wdog_flag = 1'b1;
      st_d.wdog_nmi = 1'b1;
    end
    else
      st_d.wd_count = st_q.wd_count + 1'b1;
    // nothing left to clock the device and no recovery armed
    if (!source_alive(st_q.ctrl) && !st_q.ctrl[clock_select_pkg::PRIM_FD_BIT])
      st_d.halted = 1'b1;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      st_q <= '0;
      st_q.waitreq <= 1'b1;
      st_q.lock <= clock_select_pkg::LOCK_IDLE;
      st_q.ctrl <= clock_select_pkg::CTRL_RESET;
    end
    else
      st_q <= st_d;
  end

  assign o_readdata = st_q.rdata;
  assign o_waitrequest = st_q.waitreq;
  assign o_sys_clock_source_field = st_q.ctrl[clock_select_pkg::SEL_MSB:0];
  assign o_precision_osc_en = st_q.ctrl[clock_select_pkg::PREC_EN_BIT];
  assign o_wdog_osc_en = st_q.ctrl[clock_select_pkg::WDOG_EN_BIT];
  assign o_halted = st_q.halted;
  assign o_primary_fail_nmi = st_q.prim_nmi;
  assign o_wdog_fail_nmi = st_q.wdog_nmi;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_open_loads_once: assert property ((ctrl_wr && st_q.lock == clock_select_pkg::LOCK_OPEN)
    |=> st_q.ctrl == $past(wbyte & clock_select_pkg::CTRL_WRITE_MASK)
        && st_q.lock == clock_select_pkg::LOCK_IDLE)
    else $error("unlocked write not loaded or lock not restored");
  a_locked_no_change: assert property ((st_q.lock != clock_select_pkg::LOCK_OPEN && !prim_event)
    |=> st_q.ctrl == $past(st_q.ctrl))
    else $error("control changed while locked");
  a_unlock_order: assert property ((ctrl_wr && st_q.lock == clock_select_pkg::LOCK_HALF
    && wbyte == clock_select_pkg::UNLOCK_SECOND) |=> st_q.lock == clock_select_pkg::LOCK_OPEN)
    else $error("second pattern did not unlock");
  a_other_keeps_lock: assert property ((!ctrl_wr) |=> st_q.lock == $past(st_q.lock))
    else $error("unlock progress moved without a control write");
  a_failover_switch: assert property ((prim_event && st_q.ctrl[clock_select_pkg::WDOG_EN_BIT])
    |=> o_primary_fail_nmi && o_sys_clock_source_field == clock_select_pkg::SRC_WDOG)
    else $error("primary failure without nmi and switch");
  a_no_switch_wdog_off: assert property ((prim_event && !st_q.ctrl[clock_select_pkg::WDOG_EN_BIT])
    |=> o_sys_clock_source_field == $past(o_sys_clock_source_field))
    else $error("switched to a disabled watchdog oscillator");
  a_wdog_fail_count: assert property ((st_q.wd_count == CNT_LAST && !wd_edge && !st_q.wdog_dead
    && st_q.ctrl[clock_select_pkg::WDOG_FD_BIT]) |=> o_wdog_fail_nmi && st_q.wdog_dead
    && o_sys_clock_source_field == $past(o_sys_clock_source_field))
    else $error("watchdog loss not flagged at the count limit");
  a_dead_blinds: assert property (st_q.wdog_dead |=> !o_primary_fail_nmi)
    else $error("primary failure seen after watchdog loss");
  a_halt_sticky: assert property (st_q.halted |=> st_q.halted && $stable(st_q.ctrl[7:3]))
    else $error("halted device resumed");
  a_bus_one_wait: assert property ((bus_req && st_q.waitreq) |=> !o_waitrequest ##1 o_waitrequest)
    else $error("bus answer not after exactly one wait cycle");
  // reset check must run while reset is low, so it opts out of the default disable
  a_reset_ctrl: assert property (disable iff (1'b0) !i_rstn |=> st_q.ctrl == clock_select_pkg::CTRL_RESET
    && o_waitrequest && !o_halted && !o_primary_fail_nmi && !o_wdog_fail_nmi)
    else $error("control not at reset value after reset");
  a_failover_keeps_rc: assert property (prim_event |=> o_precision_osc_en == $past(o_precision_osc_en))
    else $error("failover changed the precision oscillator enable");
  a_no_switch_on_wdog: assert property ((prim_event
    && st_q.ctrl[clock_select_pkg::SEL_MSB:0] == clock_select_pkg::SRC_WDOG) |=> o_sys_clock_source_field == clock_select_pkg::SRC_WDOG)
    else $error("source moved away from watchdog on failover");
  a_first_pattern_half: assert property ((ctrl_wr && st_q.lock == clock_select_pkg::LOCK_IDLE
    && wbyte == clock_select_pkg::UNLOCK_FIRST) |=> st_q.lock == clock_select_pkg::LOCK_HALF)
    else $error("first pattern did not advance the unlock");
  a_repeat_first_holds: assert property ((ctrl_wr && st_q.lock == clock_select_pkg::LOCK_HALF
    && wbyte == clock_select_pkg::UNLOCK_FIRST) |=> st_q.lock == clock_select_pkg::LOCK_HALF)
    else $error("repeated first pattern lost unlock progress");
  a_bad_second_idle: assert property ((ctrl_wr && st_q.lock == clock_select_pkg::LOCK_HALF && !prim_event
    && wbyte != clock_select_pkg::UNLOCK_FIRST && wbyte != clock_select_pkg::UNLOCK_SECOND)
    |=> st_q.lock == clock_select_pkg::LOCK_IDLE && st_q.ctrl == $past(st_q.ctrl))
    else $error("wrong second pattern did not return to locked");
  a_read_ctrl_data: assert property ((i_read && st_q.waitreq && i_address == clock_select_pkg::CTRL_OFFSET)
    |=> o_readdata == {24'h0, $past(st_q.ctrl)} && st_q.lock == $past(st_q.lock))
    else $error("control read returned wrong data or moved the lock");
  a_halted_no_write: assert property (st_q.halted |=> st_q.lock == $past(st_q.lock))
    else $error("write reached a halted device");
  a_halt_sets: assert property ((!source_alive(st_q.ctrl) && !st_q.ctrl[clock_select_pkg::PRIM_FD_BIT])
    |=> o_halted)
    else $error("dead source without recovery did not halt");
  a_wdog_nmi_pulse: assert property (o_wdog_fail_nmi |=> !o_wdog_fail_nmi)
    else $error("watchdog failure event longer than one cycle");
  a_prim_nmi_event: assert property (prim_event |=> o_primary_fail_nmi && st_q.prim_flag)
    else $error("primary failure event or flag missing");
  a_wd_count_clear: assert property (!st_q.ctrl[clock_select_pkg::WDOG_FD_BIT] |=> st_q.wd_count == '0)
    else $error("watchdog loss counter ran while detection off");
  a_flag_set_wins: assert property ((prim_event && stat_wr) |=> st_q.prim_flag)
    else $error("clear beat a new primary failure");
  // covers below show each main scenario is reached

  c_unlock_write: cover property (ctrl_wr && st_q.lock == clock_select_pkg::LOCK_OPEN);
  c_failover: cover property (prim_event && st_q.ctrl[clock_select_pkg::WDOG_EN_BIT]);
  c_wdog_loss: cover property (o_wdog_fail_nmi);
  c_halt: cover property (o_halted);
  c_status_clear: cover property (stat_wr && wbyte[clock_select_pkg::ST_PRIM_FAIL_BIT]);
endmodule // system_clock_select_failover
`default_nettype wire

// [test_system_clock_select_failover.sv]
/*
  self-checking bench for the system clock select and failover block.
  assumes the block answers on avalon-mm with waitrequest and runs on one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module test_system_clock_select_failover;
  logic i_clock, i_rstn, i_read, i_write, i_wdog_osc_clock, i_primary_osc_slow, o_waitrequest;
  logic [3:0] i_address;
  logic [31:0] i_writedata, o_readdata;
  logic [2:0] o_sys_clock_source_field;
  logic o_precision_osc_en, o_wdog_osc_en, o_halted, o_primary_fail_nmi, o_wdog_fail_nmi;
  int n_mismatch, compares, n_pnmi, n_wnmi, seed, i;
  logic wd_run;
  logic [7:0] q, d, r;
  system_clock_select_failover #(.WDOG_FAIL_COUNT(20)) i_system_clock_select_failover (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_wdog_osc_clock(i_wdog_osc_clock), .i_primary_osc_slow(i_primary_osc_slow),
    .o_sys_clock_source_field(o_sys_clock_source_field), .o_precision_osc_en(o_precision_osc_en),
    .o_wdog_osc_en(o_wdog_osc_en), .o_halted(o_halted), .o_primary_fail_nmi(o_primary_fail_nmi),
    .o_wdog_fail_nmi(o_wdog_fail_nmi));
  initial
  begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  // nmi pulse counters
  always @(posedge i_clock)
  begin
    if (o_primary_fail_nmi === 1'b1) n_pnmi++;
    if (o_wdog_fail_nmi === 1'b1) n_wnmi++;
  end
  // slow watchdog oscillator stand-in, stops when wd_run drops
  initial
  begin
    forever
    begin
      repeat (3) @(posedge i_clock);
      if (wd_run) i_wdog_osc_clock <= ~i_wdog_osc_clock;
    end
  end
  task automatic end_sim;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] dat, output logic [7:0] rd);
    int n;
    @(posedge i_clock);
    i_read <= !wr;
    i_write <= wr;
    i_address <= a;
    i_writedata <= {24'h0, dat};
    n = 0;
    // looked at mid-cycle, where it stands settled until the taking edge
    do
    begin
      @(negedge i_clock);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      n_mismatch++;
    rd = o_readdata[7:0];
    @(posedge i_clock);
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    logic [7:0] x;
    bus(1'b1, a, dat, x);
  endtask
  task automatic unl(input logic [7:0] dat);
    wr(4'h0, 8'he7);
    wr(4'h0, 8'h18);
    wr(4'h0, dat);
  endtask
  task automatic pulse_slow;
    i_primary_osc_slow <= 1'b1;
    repeat (8) @(posedge i_clock);
    i_primary_osc_slow <= 1'b0;
    repeat (8) @(posedge i_clock);
  endtask
  function automatic logic [7:0] masked(input logic [7:0] v);
    return v & clock_select_pkg::CTRL_WRITE_MASK;
  endfunction
  initial
  begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    {i_rstn, i_read, i_write, i_wdog_osc_clock, i_primary_osc_slow, wd_run} = 6'h0;
    i_address = 4'h0;
    i_writedata = 32'h0;
    seed = 32'haac892ab;
    repeat (20) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    chk("source", {5'h0, o_sys_clock_source_field}, 8'h00);
    chk("osc_en", {6'h0, o_precision_osc_en, o_wdog_osc_en}, 8'h03);
    bus(1'b0, 4'h0, 8'h0, q); chk("ctrl", q, 8'ha0);
    bus(1'b0, 4'h8, 8'h0, q); chk("unmapped", q, 8'h00);
    wr(4'h0, 8'h0b);
    bus(1'b0, 4'h0, 8'h0, q); chk("ctrl", q, 8'ha0);
    wr(4'h0, 8'he7);
    bus(1'b0, 4'h4, 8'h0, q); chk("lock", q, 8'h20);
    wr(4'h4, 8'h00);
    bus(1'b0, 4'h0, 8'h0, q); chk("ctrl", q, 8'ha0);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'he1);
    bus(1'b0, 4'h0, 8'h0, q); chk("ctrl", q, 8'ha1);
    wr(4'h0, 8'ha2);
    bus(1'b0, 4'h0, 8'h0, q); chk("ctrl", q, 8'ha1);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'he7);
    wr(4'h0, 8'h55);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'ha2);
    bus(1'b0, 4'h0, 8'h0, q); chk("ctrl", q, 8'ha1);
    for (i = 0; i < 10; i++)
    begin
      r = $random(seed);
      d = {1'b1, r[6], 4'h8, r[1:0]};
      wr(4'h0, 8'he7);
      bus(1'b0, 4'h4, 8'h0, q);
      wr(4'h0, 8'h18);
      wr(4'h0, d);
      bus(1'b0, 4'h0, 8'h0, q); chk("ctrl", q, masked(d));
      chk("source", {5'h0, o_sys_clock_source_field}, {6'h0, r[1:0]});
      chk("prec_en", {7'h0, o_precision_osc_en}, 8'h01);
    end
    unl(8'hb0);
    pulse_slow();
    chk("pnmi", n_pnmi[7:0], 8'h01);
    chk("source", {5'h0, o_sys_clock_source_field}, 8'h03);
    bus(1'b0, 4'h4, 8'h0, q); chk("status", q, 8'h11);
    wr(4'h4, 8'h01);
    bus(1'b0, 4'h4, 8'h0, q); chk("status", q, 8'h10);
    unl(8'h90);
    pulse_slow();
    chk("pnmi", n_pnmi[7:0], 8'h02);
    chk("source", {5'h0, o_sys_clock_source_field}, 8'h00);
    unl(8'ha0);
    pulse_slow();
    chk("pnmi", n_pnmi[7:0], 8'h02);
    wd_run <= 1'b1;
    unl(8'ha8);
    repeat (60) @(posedge i_clock);
    chk("wnmi", n_wnmi[7:0], 8'h00);
    wd_run <= 1'b0;
    repeat (10) @(posedge i_clock);
    chk("wnmi", n_wnmi[7:0], 8'h00);
    repeat (30) @(posedge i_clock);
    chk("wnmi", n_wnmi[7:0], 8'h01);
    chk("source", {5'h0, o_sys_clock_source_field}, 8'h00);
    unl(8'hb0);
    bus(1'b0, 4'h0, 8'h0, q); chk("ctrl", q, 8'hb0);
    pulse_slow();
    chk("pnmi", n_pnmi[7:0], 8'h02);
    chk("source", {5'h0, o_sys_clock_source_field}, 8'h00);
    unl(8'h21);
    repeat (3) @(posedge i_clock);
    chk("halted", {7'h0, o_halted}, 8'h01);
    unl(8'ha0);
    bus(1'b0, 4'h0, 8'h0, q); chk("ctrl", q, 8'h21);
    end_sim();
  end
endmodule // test_system_clock_select_failover
`default_nettype wire
